// ===== rtl/ttp_top.v
/*
 * Trigger placement and pattern comparators for main and external analyzers.
 * Assumes an AXI4-Lite master on core_clk and synchronous state inputs.
 *
// Summary of operation
// R1 - Start mode: trigger is first entry
// R2 - Centre mode: trigger at list middle
// R3 - End mode: trigger is last entry
// R4 - Before mode keeps offset states ahead
// R5 - After mode stores offset states behind
// R6 - Offsets limited to 0 through 1023
// R7 - Counting on: position within one state
// R8 - Counting off: position within three states
// R9 - Reset or init selects start mode
// R10 - External timing mode: start/centre/end only
// R11 - Independent placement per analyzer
// R12 - Eight indexed pattern comparators per analyzer
// R13 - Field equal/unequal tests, AND or OR
// R14 - Patterns only in complex configuration
// R15 - Patterns default to match any
// R16 - Terms reference only defined label fields
// R17 - Appended: external patterns invalid, main spans
// R18 - External analyzer has sixteen lines
// R19 - Main analyzer has 108 lines
// R20 - Post-trigger counter halts storage at expiry
 */
`timescale 1ns/1ps
`include "ttp_consts.vh"

module ttp_top (
  input wire core_clk,
  input wire resetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire mainValid,
  input wire [107:0] mainState,
  input wire mainTrig,
  input wire extValid,
  input wire [15:0] extState,
  input wire extTrig,
  output reg [7:0] mainPatHit,
  output reg [7:0] extPatHit,
  output reg mainDone,
  output reg extDone
);

  // ****************************************************************
  // Control registers
  // ****************************************************************
  reg [5:0] ctrl_r;
  reg [12:0] mPlace_r;
  reg [12:0] xPlace_r;
  reg [3:0] patSel_r;
  reg [1:0] fldSel_r;
  // Per pattern: any flag, OR flag, per field enable and inequality
  reg [15:0] patCfg_r [0:15];
  reg [6:0] fldLo_r [0:63];
  reg [31:0] fldMask_r [0:63];
  reg [31:0] fldVal_r [0:63];
  reg bPend_r;
  reg [1:0] bResp_r;
  reg [7:0] awAddr_r;
  reg [31:0] wData_r;
  reg awHave_r;
  reg wHave_r;
  integer k;

  // Mode decode used for both analyzers
  function modeOk;
    input [2:0] m;
    input [9:0] ofs;
    input timingOnly;
    begin
      modeOk = (m <= `TTP_MODE_AFTER) && (ofs <= `TTP_OFS_MAX) && // R6
               !(timingOnly && m >= `TTP_MODE_BEFORE); // R10
    end
  endfunction

  wire cplx = ctrl_r[`TTP_C_CPLX];
  wire append = ctrl_r[`TTP_C_APPEND];
  wire [5:0] fIdx = {patSel_r, fldSel_r};

  // ****************************************************************
  // AXI4-Lite write side
  // ****************************************************************
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= 6'h00;
      mPlace_r <= 13'h0000; // R9
      xPlace_r <= 13'h0000; // R9
      patSel_r <= 4'h0;
      fldSel_r <= 2'h0;
      bPend_r <= 1'b0;
      bResp_r <= `TTP_RESP_OK;
      awAddr_r <= 8'h00;
      wData_r <= 32'h00000000;
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TTP_RESP_OK;
      for (k = 0; k < 16; k = k + 1) begin
        patCfg_r[k] <= 16'h0001; // R15
      end
    end else begin
      s_axi_awready <= !awHave_r && !bPend_r && !s_axi_awready;
      s_axi_wready <= !wHave_r && !bPend_r && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
      end
      if (awHave_r && wHave_r && !bPend_r) begin
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
        bPend_r <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `TTP_RESP_OK;
        case (awAddr_r)
          `TTP_A_CTRL: begin
            ctrl_r <= wData_r[5:0];
            if (wData_r[`TTP_C_INIT]) begin
              mPlace_r <= 13'h0000; // R9
              xPlace_r <= 13'h0000;
              ctrl_r <= 6'h00;
              for (k = 0; k < 16; k = k + 1) begin
                patCfg_r[k] <= 16'h0001; // R15
              end
            end
          end
          `TTP_A_MPLACE: begin
            if (modeOk(wData_r[12:10], wData_r[9:0], 1'b0)) begin
              mPlace_r <= wData_r[12:0]; // R11
            end else begin
              s_axi_bresp <= `TTP_RESP_SLVERR; // R6
            end
          end
          `TTP_A_XPLACE: begin
            if (modeOk(wData_r[12:10], wData_r[9:0], ctrl_r[`TTP_C_XTIMING])) begin
              xPlace_r <= wData_r[12:0]; // R11
            end else begin
              s_axi_bresp <= `TTP_RESP_SLVERR; // R10
            end
          end
          `TTP_A_PATSEL: begin
            patSel_r <= wData_r[3:0]; // R12
            fldSel_r <= wData_r[9:8];
          end
          `TTP_A_PATCFG: begin
            if (cplx) begin
              patCfg_r[patSel_r] <= wData_r[15:0]; // R13
            end else begin
              s_axi_bresp <= `TTP_RESP_SLVERR; // R14
            end
          end
          `TTP_A_PATFLD: begin
            // Table itself is written by the field process below
            if (!cplx) begin
              s_axi_bresp <= `TTP_RESP_SLVERR; // R14
            end
          end
          default: s_axi_bresp <= `TTP_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        bPend_r <= 1'b0;
      end
    end
  end

  // Field tables: low line index, mask and value each written by its own word, chosen by bits 31:30
  always @(posedge core_clk) begin
    if (awHave_r && wHave_r && !bPend_r && awAddr_r == `TTP_A_PATFLD && cplx) begin
      case (wData_r[31:30])
        2'h0: fldLo_r[fIdx] <= wData_r[6:0]; // R16
        2'h1: fldMask_r[fIdx] <= {2'h0, wData_r[29:0]};
        default: fldVal_r[fIdx] <= {2'h0, wData_r[29:0]};
      endcase
    end
  end

  // ****************************************************************
  // Pattern comparators
  // ****************************************************************
  wire [123:0] spanBus = {extState, mainState}; // R18 R19
  wire [15:0] patRaw;
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : gPat
      wire [3:0] fHit;
      wire [3:0] fEn = patCfg_r[g][5:2];
      genvar f;
      for (f = 0; f < 4; f = f + 1) begin : gFld
        wire [6:0] lo = fldLo_r[g*4+f];
        wire [123:0] src = (g < 8) ? (append ? spanBus : {16'h0000, mainState})
                           : {108'h0, extState}; // R17
        wire [31:0] slice = src[lo +: 32] & fldMask_r[g*4+f];
        wire eq = slice == (fldVal_r[g*4+f] & fldMask_r[g*4+f]);
        assign fHit[f] = eq ^ patCfg_r[g][6+f]; // R13
      end
      wire andHit = &(fHit | ~fEn);
      wire orHit = |(fHit & fEn);
      assign patRaw[g] = patCfg_r[g][0] | (patCfg_r[g][1] ? orHit : andHit); // R13
    end
  endgenerate

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mainPatHit <= 8'h00;
      extPatHit <= 8'h00;
    end else begin
      mainPatHit <= cplx ? patRaw[7:0] : 8'h00; // R14
      extPatHit <= (cplx && !append) ? patRaw[15:8] : 8'h00; // R17
    end
  end

  // ****************************************************************
  // Capture engines
  // ****************************************************************
  wire mRun, mDn, xRun, xDn;
  wire [9:0] mTrigIdx, xTrigIdx;
  wire [107:0] mRd;
  wire [15:0] xRd;

  ttp_capture #(.W(`TTP_MAIN_W)) uMain (
    .core_clk(core_clk),
    .resetn(resetn),
    .arm(ctrl_r[`TTP_C_ARM]),
    .mode(mPlace_r[12:10]),
    .offset(mPlace_r[9:0]),
    .stateValid(mainValid),
    .stateData(mainState),
    .trigHit(mainTrig),
    .rdAddr(10'h000),
    .rdData(mRd),
    .running(mRun),
    .done(mDn),
    .trigIndex(mTrigIdx)
  );

  ttp_capture #(.W(`TTP_EXT_W)) uExt (
    .core_clk(core_clk),
    .resetn(resetn),
    .arm(ctrl_r[`TTP_C_ARM] && !append),
    .mode(xPlace_r[12:10]),
    .offset(xPlace_r[9:0]),
    .stateValid(extValid),
    .stateData(extState),
    .trigHit(extTrig),
    .rdAddr(10'h000),
    .rdData(xRd),
    .running(xRun),
    .done(xDn),
    .trigIndex(xTrigIdx)
  );

  // ****************************************************************
  // AXI4-Lite read side
  // ****************************************************************
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TTP_RESP_OK;
      mainDone <= 1'b0;
      extDone <= 1'b0;
    end else begin
      mainDone <= mDn;
      extDone <= xDn;
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `TTP_RESP_OK;
        case (s_axi_araddr[7:0])
          `TTP_A_CTRL: s_axi_rdata <= {26'h0, ctrl_r};
          `TTP_A_MPLACE: s_axi_rdata <= {19'h0, mPlace_r};
          `TTP_A_XPLACE: s_axi_rdata <= {19'h0, xPlace_r};
          `TTP_A_STAT: s_axi_rdata <= {28'h0, xDn, xRun, mDn, mRun};
          `TTP_A_MTRIG: s_axi_rdata <= {22'h0, mTrigIdx};
          `TTP_A_XTRIG: s_axi_rdata <= {22'h0, xTrigIdx};
          `TTP_A_PATSEL: s_axi_rdata <= {22'h0, fldSel_r, 4'h0, patSel_r};
          `TTP_A_PATCFG: s_axi_rdata <= {16'h0, patCfg_r[patSel_r]};
          `TTP_A_PATHITS: s_axi_rdata <= {16'h0, extPatHit, mainPatHit};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TTP_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ===== rtl/ttp_consts.vh
/*
 * Constants for the trigger placement and pattern comparator block.
 * Assumes inclusion by bare name from the rtl directory.
 */
`ifndef TTP_CONSTS_VH
`define TTP_CONSTS_VH

// ****************************************************************
// Widths
// ****************************************************************
`define TTP_MAIN_W 108
`define TTP_EXT_W 16
`define TTP_ALL_W 124
`define TTP_DEPTH 1024
`define TTP_AW 10
`define TTP_OFS_MAX 10'h3ff
`define TTP_CENTRE 10'h200
`define TTP_NPAT 8

// ****************************************************************
// Placement mode codes
// ****************************************************************
`define TTP_MODE_START 3'h0
`define TTP_MODE_CENTRE 3'h1
`define TTP_MODE_END 3'h2
`define TTP_MODE_BEFORE 3'h3
`define TTP_MODE_AFTER 3'h4

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define TTP_A_CTRL 8'h00
`define TTP_A_MPLACE 8'h04
`define TTP_A_XPLACE 8'h08
`define TTP_A_STAT 8'h0c
`define TTP_A_MTRIG 8'h10
`define TTP_A_XTRIG 8'h14
`define TTP_A_PATSEL 8'h18
`define TTP_A_PATCFG 8'h1c
`define TTP_A_PATFLD 8'h20
`define TTP_A_PATHITS 8'h24

// ****************************************************************
// Control fields
// ****************************************************************
`define TTP_C_ARM 0
`define TTP_C_INIT 1
`define TTP_C_CPLX 2
`define TTP_C_APPEND 3
`define TTP_C_XTIMING 4
`define TTP_C_COUNTING 5

// ****************************************************************
// Misc
// ****************************************************************
`define TTP_RESP_OK 2'h0
`define TTP_RESP_SLVERR 2'h2
`define TTP_NFLD 4
`define TTP_FLD_W 32

`endif

// ===== rtl/ttp_capture.v
/*
 * One capture engine: trace memory, trigger placement, post-trigger count.
 * Assumes synchronous state strobes and a settled placement while armed.
 */
`timescale 1ns/1ps
`include "ttp_consts.vh"

module ttp_capture #(
  parameter W = 108
) (
  input wire core_clk,
  input wire resetn,
  input wire arm,
  input wire [2:0] mode,
  input wire [9:0] offset,
  input wire stateValid,
  input wire [W-1:0] stateData,
  input wire trigHit,
  input wire [9:0] rdAddr,
  output reg [W-1:0] rdData,
  output reg running,
  output reg done,
  output reg [9:0] trigIndex
);

  // ****************************************************************
  // Storage and counters
  // ****************************************************************
  reg [W-1:0] mem [0:`TTP_DEPTH-1];
  reg [9:0] wrPtr_r;
  reg [10:0] fill_r;
  reg [10:0] post_r;
  reg triggered_r;
  reg [9:0] trigPtr_r;
  reg [10:0] postLoad;

  // Post count: states stored after the trigger itself
  always @* begin
    case (mode)
      `TTP_MODE_START: postLoad = {1'b0, `TTP_OFS_MAX}; // R1
      `TTP_MODE_CENTRE: postLoad = {1'b0, `TTP_CENTRE} - 11'h001; // R2
      `TTP_MODE_END: postLoad = 11'h000; // R3
      `TTP_MODE_BEFORE: postLoad = {1'b0, `TTP_OFS_MAX - offset}; // R4
      `TTP_MODE_AFTER: postLoad = {1'b0, offset}; // R5
      default: postLoad = {1'b0, `TTP_OFS_MAX};
    endcase
  end

  always @(posedge core_clk) begin
    if (running && stateValid) begin
      mem[wrPtr_r] <= stateData;
    end
    rdData <= mem[wrPtr_r + rdAddr + (done ? 10'h000 : 10'h000)];
  end

  // Exact placement: every state is stored, so error is zero, inside both tolerances
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= 10'h000;
      fill_r <= 11'h000;
      post_r <= 11'h000;
      triggered_r <= 1'b0;
      trigPtr_r <= 10'h000;
      running <= 1'b0;
      done <= 1'b0;
      trigIndex <= 10'h000;
    end else if (!arm) begin
      // Disarm also clears done, otherwise the next arm never restarts
      running <= 1'b0;
      done <= 1'b0;
      triggered_r <= 1'b0;
      fill_r <= 11'h000;
    end else if (!running && !done) begin
      running <= 1'b1;
      wrPtr_r <= 10'h000;
    end else if (running && stateValid) begin
      wrPtr_r <= wrPtr_r + 10'h001;
      if (fill_r != `TTP_DEPTH) begin
        fill_r <= fill_r + 11'h001;
      end
      if (!triggered_r && trigHit) begin
        triggered_r <= 1'b1;
        trigPtr_r <= wrPtr_r;
        post_r <= postLoad; // R20 R7 R8
        if (postLoad == 11'h000) begin
          running <= 1'b0;
          done <= 1'b1;
          trigIndex <= (fill_r == `TTP_DEPTH) ? `TTP_OFS_MAX : fill_r[9:0];
        end
      end else if (triggered_r) begin
        post_r <= post_r - 11'h001;
        if (post_r == 11'h001) begin
          running <= 1'b0; // R20
          done <= 1'b1;
          // Trigger index measured from oldest kept entry
          trigIndex <= (fill_r >= 11'h3ff) ? (trigPtr_r - wrPtr_r - 10'h001)
                       : trigPtr_r;
        end
      end
    end
  end

endmodule

// ===== test/ttp_top_properties.sv
/*
 * Checker on the top ports: pattern hits and capture completion.
 * Assumes write address and data are taken on the same edge.
 */
`timescale 1ns/1ps
`include "ttp_consts.vh"
module ttp_top_props (
  input wire core_clk,
  input wire resetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire mainValid,
  input wire mainTrig,
  input wire extValid,
  input wire extTrig,
  input wire [7:0] mainPatHit,
  input wire [7:0] extPatHit,
  input wire mainDone,
  input wire extDone
);
  // ********
  // Shadow of the settings
  // ********
  wire wrHs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire [7:0] wrA = s_axi_awaddr[7:0];
  wire ctrlWr = wrHs && wrA == `TTP_A_CTRL;
  wire patWr = wrHs && (wrA == `TTP_A_PATCFG || wrA == `TTP_A_PATFLD);
  wire initWr = ctrlWr && s_axi_wdata[`TTP_C_INIT];
  reg cplx_r, app_r, touch_r, mSeen_r, xSeen_r;
  reg [1:0] quiet_r;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      {cplx_r, app_r, touch_r, mSeen_r, xSeen_r, quiet_r} <= 7'h0;
    end else begin
      if (ctrlWr) begin
        cplx_r <= s_axi_wdata[`TTP_C_CPLX] && !initWr;
        app_r <= s_axi_wdata[`TTP_C_APPEND] && !initWr;
      end
      // Refused pattern writes in easy mode leave the defaults alone
      touch_r <= !initWr && (touch_r || (patWr && cplx_r));
      mSeen_r <= !ctrlWr && (mSeen_r || (mainValid && mainTrig));
      xSeen_r <= !ctrlWr && (xSeen_r || (extValid && extTrig));
      quiet_r <= ctrlWr ? 2'h0 : quiet_r + {1'b0, quiet_r != 2'h3};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Shadow leads the design's control register by one edge, hits by two
  sequence s_freshMain; cplx_r && $past(cplx_r) && !touch_r && mainValid; endsequence
  sequence s_freshExt;
    cplx_r && $past(cplx_r) && !app_r && !$past(app_r) && !touch_r && extValid;
  endsequence
  property p_easy;
    !cplx_r && !$past(cplx_r) && !$past(cplx_r, 2) |-> mainPatHit == 8'h0 && extPatHit == 8'h0;
  endproperty
  property p_append; app_r && $past(app_r) && $past(app_r, 2) |-> extPatHit == 8'h0; endproperty
  property p_anyMain; s_freshMain |=> mainPatHit == 8'hff; endproperty
  property p_anyExt; s_freshExt |=> extPatHit == 8'hff; endproperty
  property p_mCause; $rose(mainDone) |-> mSeen_r; endproperty
  property p_xCause; $rose(extDone) |-> xSeen_r; endproperty
  property p_mHold; mainDone && quiet_r == 2'h3 |=> mainDone; endproperty
  property p_xHold; extDone && quiet_r == 2'h3 |=> extDone; endproperty
  a_easy: assert property (p_easy) else $error("hit in easy mode");
  a_append: assert property (p_append) else $error("ext hit appended");
  a_anyMain: assert property (p_anyMain) else $error("main not any");
  a_anyExt: assert property (p_anyExt) else $error("ext not any");
  a_mCause: assert property (p_mCause) else $error("main done early");
  a_xCause: assert property (p_xCause) else $error("ext done early");
  a_mHold: assert property (p_mHold) else $error("main done lost");
  a_xHold: assert property (p_xHold) else $error("ext done lost");
endmodule
bind ttp_top ttp_top_props u_ttp_top_props (.*);

// ===== test/ttp_bus_model.sv
/*
 * Traced bus model: counting states, one trigger per run.
 * Assumes run is raised after an edge and held for a capture.
 */
`timescale 1ns/1ps
module ttp_bus_model (
  input wire core_clk,
  input wire resetn,
  input wire run,
  input wire slow,
  output logic mainValid,
  output logic [107:0] mainState,
  output logic mainTrig,
  output wire extValid,
  output wire [15:0] extState,
  output wire extTrig
);
  // ********
  // Stream
  // ********
  reg [15:0] cnt_r;
  reg phase_r;
  assign extValid = mainValid;
  assign extState = mainState[15:0];
  assign extTrig = mainTrig;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      {cnt_r, phase_r, mainValid, mainTrig} <= 19'h0;
      mainState <= 108'h0;
    end else begin
      phase_r <= !phase_r;
      // Trigger after more states than the list holds
      if (run && (!slow || phase_r)) begin
        mainValid <= 1'b1;
        mainState <= {9{cnt_r[11:0]}};
        mainTrig <= cnt_r == 16'd1100;
        cnt_r <= cnt_r + 16'h1;
      end else begin
        mainValid <= 1'b0;
        mainTrig <= 1'b0;
        // Idle lines toggle so stale data never looks fresh
        mainState <= ~mainState;
      end
      if (!run) cnt_r <= 16'h0;
    end
  end
endmodule

// ===== test/tb_ttp_top.sv
/*
 * Bench: registers, captures in every placement, patterns.
 * Assumes the bus model on the state inputs and the bound checker.
 */
`timescale 1ns/1ps
`include "ttp_consts.vh"
module tb_ttp_top;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, run = 1'b0, slow = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire mainValid, mainTrig, extValid, extTrig, mainDone, extDone;
  wire [107:0] mainState;
  wire [15:0] extState;
  wire [7:0] mainPatHit, extPatHit;
  logic [31:0] rdat;
  logic [1:0] rsp;
  integer nErrors = 0;
  integer numChecks = 0;
  ttp_top u_ttp_top (.*);
  ttp_bus_model u_ttp_bus_model (.*);
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // ********
  // Shared tasks
  // ********
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    numChecks = numChecks + 1;
    if (got !== exp) begin
      nErrors = nErrors + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    if (nErrors == 0 && numChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic aOk, wOk, done;
    done = 1'b0;
    if (w) begin
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
    end else begin
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
    end
    // Sample at the falling edge: the value seen by the next rising edge
    repeat (100) if (!done) begin
      @(negedge core_clk);
      aOk = w ? s_axi_awready : s_axi_arready;
      wOk = w && s_axi_wready;
      done = w ? s_axi_bvalid : s_axi_rvalid;
      rsp = w ? s_axi_bresp : s_axi_rresp;
      rdat = s_axi_rdata;
      @(posedge core_clk);
      if (aOk && w) s_axi_awvalid <= 1'b0;
      if (aOk && !w) s_axi_arvalid <= 1'b0;
      if (wOk) s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bus(1'b1, a, d);
    chk(rsp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  // ********
  // Scenarios
  // ********
  task t_regs;
    rd(`TTP_A_MPLACE, 32'h0);
    rd(`TTP_A_XPLACE, 32'h0);
    rd(`TTP_A_STAT, 32'h0);
    bus(1'b0, 8'h30, 32'h0);
    chk(rsp, `TTP_RESP_SLVERR);
    wr(`TTP_A_MPLACE, 32'h13ff, `TTP_RESP_OK);
    wr(`TTP_A_XPLACE, 32'h0400, `TTP_RESP_OK);
    rd(`TTP_A_MPLACE, 32'h13ff);
    wr(`TTP_A_CTRL, 32'h2, `TTP_RESP_OK);
    rd(`TTP_A_MPLACE, 32'h0);
    rd(`TTP_A_XPLACE, 32'h0);
  endtask
  task t_refuse;
    wr(`TTP_A_MPLACE, 32'h1400, `TTP_RESP_SLVERR);
    rd(`TTP_A_MPLACE, 32'h0);
    wr(`TTP_A_PATCFG, 32'h1, `TTP_RESP_SLVERR);
    wr(`TTP_A_CTRL, 32'h10, `TTP_RESP_OK);
    wr(`TTP_A_XPLACE, 32'h1005, `TTP_RESP_SLVERR);
    wr(`TTP_A_XPLACE, 32'h0800, `TTP_RESP_OK);
    rd(`TTP_A_XPLACE, 32'h0800);
    wr(`TTP_A_MPLACE, 32'h0c05, `TTP_RESP_OK);
  endtask
  task automatic cap(input logic [31:0] mp, xp, ctl, input logic [9:0] em, ex, input logic sl);
    wr(`TTP_A_CTRL, ctl, `TTP_RESP_OK);
    wr(`TTP_A_MPLACE, mp, `TTP_RESP_OK);
    wr(`TTP_A_XPLACE, xp, `TTP_RESP_OK);
    wr(`TTP_A_CTRL, ctl | 32'h1, `TTP_RESP_OK);
    slow <= sl;
    run <= 1'b1;
    repeat (6000) if (!(mainDone && extDone)) @(negedge core_clk);
    @(posedge core_clk);
    run <= 1'b0;
    chk({mainDone, extDone}, 2'h3);
    rd(`TTP_A_MTRIG, {22'h0, em});
    rd(`TTP_A_XTRIG, {22'h0, ex});
  endtask
  task automatic obs(input logic inv);
    logic [7:0] prev;
    @(negedge core_clk);
    prev = mainState[7:0];
    repeat (300) begin
      @(negedge core_clk);
      chk(mainPatHit[1:0], {1'b1, (prev == 8'h55) ^ inv});
      prev = mainState[7:0];
    end
    @(posedge core_clk);
  endtask
  task t_patterns;
    wr(`TTP_A_CTRL, 32'h4, `TTP_RESP_OK);
    slow <= 1'b0;
    run <= 1'b1;
    repeat (4) @(negedge core_clk);
    chk({mainPatHit, extPatHit}, 16'hffff);
    @(posedge core_clk);
    wr(`TTP_A_PATSEL, 32'h0, `TTP_RESP_OK);
    wr(`TTP_A_PATFLD, 32'h0, `TTP_RESP_OK);
    wr(`TTP_A_PATFLD, 32'h400000ff, `TTP_RESP_OK);
    wr(`TTP_A_PATFLD, 32'h80000055, `TTP_RESP_OK);
    wr(`TTP_A_PATCFG, 32'h4, `TTP_RESP_OK);
    obs(1'b0);
    wr(`TTP_A_PATCFG, 32'h44, `TTP_RESP_OK);
    obs(1'b1);
    wr(`TTP_A_CTRL, 32'hc, `TTP_RESP_OK);
    repeat (3) @(negedge core_clk);
    chk(extPatHit, 8'h0);
    @(posedge core_clk);
    run <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_regs;
    t_refuse;
    cap(32'h0, 32'h800, 32'h0, 10'h0, 10'h3ff, 1'b0);
    cap(32'h400, 32'hfff, 32'h0, 10'h200, 10'h3ff, 1'b1);
    cap(32'hc00, 32'h1000, 32'h0, 10'h0, 10'h3ff, 1'b0);
    cap(32'h1007, 32'hc05, 32'h20, 10'h3f8, 10'h5, 1'b0);
    t_patterns;
    close_out;
  end
  initial begin
    #(4 * 60000);
    nErrors = nErrors + 1;
    close_out;
  end
endmodule
